// ===== hdl/uspr_cfg.svh
// Purpose: Named constants for the push/carry-clear/return execution block
// Assumes: 8-bit core, 16-bit program counter, 16-bit system stack pointer
// Notes:   Cycle counts are whole instruction times at the core clock, except USPR_CYC_PTR_RD and USPR_CYC_SRC_RD, which are push cycle numbers
`ifndef USPR_CFG_SVH
`define USPR_CFG_SVH

`define USPR_OPC_PUSHINC    8'h83
`define USPR_OPC_CLRC       8'hCF
`define USPR_OPC_RETURN     8'hAF
`define USPR_CYC_PUSHINC    4'h8
`define USPR_CYC_CLRC       4'h4
`define USPR_CYC_RETURN     4'h8
`define USPR_CYC_RETURN_EXT 4'hA
`define USPR_CYC_PTR_RD     4'h5
`define USPR_CYC_SRC_RD     4'h6
`define USPR_SP_STEP        16'h0002
`define USPR_PTR_STEP       8'h01
`define USPR_FLAG_CARRY     3'h7
`define USPR_PC_RESET       16'h0000
`define USPR_SP_RESET       16'h0000
`define USPR_FLAGS_RESET    8'h00

`endif

// ===== hdl/uspr_exec.sv
// Purpose: Executes the incrementing user-stack push, carry clear and return
// Assumes: Program and stack memories answer within the cycle that presents the address
// Notes:   Other opcodes are skipped in one four-cycle slot
// Operation
// - Push-increment (83h, 3 bytes, 8 cycles) adds one to the pointer, then writes src there.
// - Push-increment leaves every condition flag as it was.
// - Carry clear keeps every other condition flag.
// - Return loads the program counter from the word at the stack pointer, then adds two.
// - The byte at the stack pointer is the counter's upper byte, the next byte the lower.
// - Return (AFh, 1 byte) takes 8 cycles, or 10 with ext_stack_i, and keeps all flags.
// - After a return, fetching resumes at the newly loaded program counter.
`include "uspr_cfg.svh"
module uspr_exec (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // Program memory
    output logic [15:0]      prog_addr_o,
    input  wire logic [7:0]  prog_data_i,
    // System stack memory
    output logic [15:0]      stk_addr_o,
    input  wire logic [7:0]  stk_data_i,
    input  wire logic        ext_stack_i,
    // Register file
    output logic             rf_rd_en_o,
    output logic [7:0]       rf_rd_addr_o,
    input  wire logic [7:0]  rf_rd_data_i,
    output logic             rf_wr_en_o,
    output logic [7:0]       rf_wr_addr_o,
    output logic [7:0]       rf_wr_data_o,
    // Core state
    output logic [15:0]      program_counter_o,
    output logic [15:0]      system_stack_pointer_o,
    output logic [7:0]       flags_o,
    output logic             instr_done_o
);
    uspr_rf_if rf ();

    uspr_pkg::uspr_state_t state_q, state_d;
    logic [15:0] pc_q, pc_d;
    logic [15:0] sp_q, sp_d;
    logic [7:0]  flags_q, flags_d;
    logic [7:0]  dst_q, dst_d;
    logic [7:0]  src_q, src_d;
    logic [7:0]  ptr_q, ptr_d;
    logic [7:0]  hi_q, hi_d;
    logic [3:0]  cyc_q, cyc_d;
    logic [3:0]  len_q, len_d;
    logic        done_q, done_d;
    logic [15:0] stk_addr_q, stk_addr_d;

    function automatic logic [7:0] ptr_inc(input logic [7:0] p);
        // Natural 8-bit wrap, no carry out is kept
        ptr_inc = p + `USPR_PTR_STEP;
    endfunction

    always_comb
    begin
        state_d    = state_q;
        pc_d       = pc_q;
        sp_d       = sp_q;
        flags_d    = flags_q;
        dst_d      = dst_q;
        src_d      = src_q;
        ptr_d      = ptr_q;
        hi_d       = hi_q;
        len_d      = len_q;
        stk_addr_d = stk_addr_q;
        done_d     = 1'b0;
        cyc_d      = cyc_q + 4'h1;
        rf.rd_en   = 1'b0;
        rf.rd_addr = 8'h00;
        rf.wr_en   = 1'b0;
        rf.wr_addr = 8'h00;
        rf.wr_data = 8'h00;
        case (state_q)
            uspr_pkg::ST_FETCH:
            begin
                cyc_d   = 4'h1;
                state_d = uspr_pkg::ST_DECODE;
            end
            uspr_pkg::ST_DECODE:
            begin
                pc_d = pc_q + 16'h0001;
                case (prog_data_i)
                    `USPR_OPC_PUSHINC:
                    begin
                        len_d   = `USPR_CYC_PUSHINC;
                        state_d = uspr_pkg::ST_OPND1;
                    end
                    `USPR_OPC_CLRC:
                    begin
                        flags_d[`USPR_FLAG_CARRY] = 1'b0;
                        len_d   = `USPR_CYC_CLRC;
                        state_d = uspr_pkg::ST_PAD;
                    end
                    `USPR_OPC_RETURN:
                    begin
                        len_d      = ext_stack_i ? `USPR_CYC_RETURN_EXT
                                                 : `USPR_CYC_RETURN;
                        stk_addr_d = sp_q;
                        state_d    = uspr_pkg::ST_STK_HI;
                    end
                    default:
                    begin
                        len_d   = `USPR_CYC_CLRC;
                        state_d = uspr_pkg::ST_PAD;
                    end
                endcase
            end
            uspr_pkg::ST_OPND1:
            begin
                dst_d   = prog_data_i;
                pc_d    = pc_q + 16'h0001;
                state_d = uspr_pkg::ST_OPND2;
            end
            uspr_pkg::ST_OPND2:
            begin
                src_d      = prog_data_i;
                pc_d       = pc_q + 16'h0001;
                rf.rd_en   = 1'b1;
                rf.rd_addr = dst_q;
                state_d    = uspr_pkg::ST_PTR_RD;
            end
            uspr_pkg::ST_PTR_RD:
            begin
                // Pin read data lags the strobe by the port register plus memory
                if (cyc_q == `USPR_CYC_PTR_RD)
                begin
                    ptr_d      = ptr_inc(rf.rd_data);
                    rf.wr_en   = 1'b1;
                    rf.wr_addr = dst_q;
                    rf.wr_data = ptr_inc(rf.rd_data);
                    rf.rd_en   = 1'b1;
                    rf.rd_addr = src_q;
                    state_d    = uspr_pkg::ST_SRC_RD;
                end
            end
            uspr_pkg::ST_SRC_RD:
            begin
                if (cyc_q == `USPR_CYC_SRC_RD)
                    state_d = uspr_pkg::ST_PUSH_WR;
            end
            uspr_pkg::ST_PUSH_WR:
            begin
                // Flags untouched on this path
                rf.wr_en   = 1'b1;
                rf.wr_addr = ptr_q;
                rf.wr_data = rf.rd_data;
                state_d    = uspr_pkg::ST_PAD;
            end
            uspr_pkg::ST_STK_HI:
            begin
                hi_d       = stk_data_i;
                stk_addr_d = stk_addr_q + 16'h0001;
                state_d    = uspr_pkg::ST_STK_LO;
            end
            uspr_pkg::ST_STK_LO:
            begin
                pc_d    = {hi_q, stk_data_i};
                sp_d    = sp_q + `USPR_SP_STEP;
                state_d = uspr_pkg::ST_PAD;
            end
            uspr_pkg::ST_PAD:
            begin
                // Decode follows done directly: the next opcode already stands on
                // the program bus, and a fetch slot here would stretch every count
                if (cyc_q >= len_q)
                begin
                    done_d  = 1'b1;
                    cyc_d   = 4'h1;
                    state_d = uspr_pkg::ST_DECODE;
                end
            end
            default:
                state_d = uspr_pkg::ST_FETCH;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_q    <= uspr_pkg::ST_FETCH;
            pc_q       <= `USPR_PC_RESET;
            sp_q       <= `USPR_SP_RESET;
            flags_q    <= `USPR_FLAGS_RESET;
            dst_q      <= 8'h00;
            src_q      <= 8'h00;
            ptr_q      <= 8'h00;
            hi_q       <= 8'h00;
            cyc_q      <= 4'h0;
            len_q      <= 4'h0;
            done_q     <= 1'b0;
            stk_addr_q <= 16'h0000;
        end
        else
        begin
            state_q    <= state_d;
            pc_q       <= pc_d;
            sp_q       <= sp_d;
            flags_q    <= flags_d;
            dst_q      <= dst_d;
            src_q      <= src_d;
            ptr_q      <= ptr_d;
            hi_q       <= hi_d;
            cyc_q      <= cyc_d;
            len_q      <= len_d;
            done_q     <= done_d;
            stk_addr_q <= stk_addr_d;
        end
    end

    uspr_rf_port u_rf_port (
        .clk_i        (clk_i),
        .arst_n_i     (arst_n_i),
        .rf           (rf),
        .rf_rd_en_o   (rf_rd_en_o),
        .rf_rd_addr_o (rf_rd_addr_o),
        .rf_rd_data_i (rf_rd_data_i),
        .rf_wr_en_o   (rf_wr_en_o),
        .rf_wr_addr_o (rf_wr_addr_o),
        .rf_wr_data_o (rf_wr_data_o)
    );

    assign prog_addr_o            = pc_q;
    assign stk_addr_o             = stk_addr_q;
    assign program_counter_o      = pc_q;
    assign system_stack_pointer_o = sp_q;
    assign flags_o                = flags_q;
    assign instr_done_o           = done_q;
endmodule

// ===== hdl/uspr_pkg.sv
// Purpose: Types used by the execution block's sequencer state machine
// Assumes: Nothing beyond the constants header
// Notes:   Holds types only
package uspr_pkg;
    typedef enum logic [3:0] {
        ST_FETCH,
        ST_DECODE,
        ST_OPND1,
        ST_OPND2,
        ST_PTR_RD,
        ST_SRC_RD,
        ST_PUSH_WR,
        ST_STK_HI,
        ST_STK_LO,
        ST_PAD
    } uspr_state_t;
endpackage

// ===== hdl/uspr_rf_if.sv
// Purpose: Register-file access bundle between sequencer and port module
// Assumes: Single-cycle synchronous read of the register file
// Notes:   One read and one write channel
interface uspr_rf_if;
    logic       rd_en;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    modport seq (output rd_en, output rd_addr, input rd_data,
                 output wr_en, output wr_addr, output wr_data);
    modport port (input rd_en, input rd_addr, output rd_data,
                  input wr_en, input wr_addr, input wr_data);
endinterface

// ===== hdl/uspr_rf_port.sv
// Purpose: Registers the register-file strobes onto the top-level pins
// Assumes: Register file answers one cycle after a read strobe
// Notes:   Read data passes straight back, it is already on the core clock
`include "uspr_cfg.svh"
module uspr_rf_port (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    // Sequencer side
    uspr_rf_if.port         rf,
    // Register-file pins
    output logic            rf_rd_en_o,
    output logic [7:0]      rf_rd_addr_o,
    input  wire logic [7:0] rf_rd_data_i,
    output logic            rf_wr_en_o,
    output logic [7:0]      rf_wr_addr_o,
    output logic [7:0]      rf_wr_data_o
);
    logic       rd_en_d;
    logic [7:0] rd_addr_d;
    logic       wr_en_d;
    logic [7:0] wr_addr_d;
    logic [7:0] wr_data_d;

    always_comb
    begin
        rd_en_d   = rf.rd_en;
        rd_addr_d = rf.rd_addr;
        wr_en_d   = rf.wr_en;
        wr_addr_d = rf.wr_addr;
        wr_data_d = rf.wr_data;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rf_rd_en_o   <= 1'b0;
            rf_rd_addr_o <= 8'h00;
            rf_wr_en_o   <= 1'b0;
            rf_wr_addr_o <= 8'h00;
            rf_wr_data_o <= 8'h00;
        end
        else
        begin
            rf_rd_en_o   <= rd_en_d;
            rf_rd_addr_o <= rd_addr_d;
            rf_wr_en_o   <= wr_en_d;
            rf_wr_addr_o <= wr_addr_d;
            rf_wr_data_o <= wr_data_d;
        end
    end

    assign rf.rd_data = rf_rd_data_i;
endmodule

// ===== verif/uspr_exec_bench.sv
// Purpose: Runs a short program through the execution block and checks results
// Assumes: Bench models program memory, stack memory and register file
// Notes:   Cycle counts are measured from one done pulse to the next
module uspr_exec_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic [15:0] prog_addr_o, stk_addr_o, program_counter_o, system_stack_pointer_o;
    logic [7:0]  prog_data_i = 8'h00, stk_data_i = 8'h00, rf_rd_data_i = 8'h00;
    logic        ext_stack_i = 1'b0;
    logic        rf_rd_en_o, rf_wr_en_o, instr_done_o;
    logic [7:0]  rf_rd_addr_o, rf_wr_addr_o, rf_wr_data_o, flags_o;
    logic [7:0]  prog [0:65535];
    logic [7:0]  stk [0:15];
    logic [7:0]  rf [0:255];
    int          mismatches = 0;
    int          n_tests = 0;
    int          cyc;

    uspr_exec DUT (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .prog_addr_o(prog_addr_o),
        .prog_data_i(prog_data_i), .stk_addr_o(stk_addr_o), .stk_data_i(stk_data_i),
        .ext_stack_i(ext_stack_i), .rf_rd_en_o(rf_rd_en_o), .rf_rd_addr_o(rf_rd_addr_o),
        .rf_rd_data_i(rf_rd_data_i), .rf_wr_en_o(rf_wr_en_o), .rf_wr_addr_o(rf_wr_addr_o),
        .rf_wr_data_o(rf_wr_data_o), .program_counter_o(program_counter_o),
        .system_stack_pointer_o(system_stack_pointer_o), .flags_o(flags_o),
        .instr_done_o(instr_done_o)
    );

    initial
    begin
        forever #10 clk_i = ~clk_i;
    end

    // Memories answer at the falling edge, well clear of the sampling edge;
    // the register file holds its byte from one read strobe to the next
    always @(negedge clk_i)
    begin
        prog_data_i <= prog[prog_addr_o];
        stk_data_i  <= stk[stk_addr_o[3:0]];
        if (rf_rd_en_o === 1'b1)
            rf_rd_data_i <= rf[rf_rd_addr_o];
    end

    always @(posedge clk_i)
    begin
        if (rf_wr_en_o === 1'b1)
            rf[rf_wr_addr_o] <= rf_wr_data_o;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("mismatches %0d, n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Counts edges up to the next done pulse; a hang ends the run
    task automatic wait_done();
        cyc = 0;
        do
        begin
            @(posedge clk_i);
            #1;
            cyc++;
            if (cyc > 20)
            begin
                mismatches++;
                $display("Error at %0t: done never came", $time);
                end_sim();
            end
        end while (instr_done_o !== 1'b1);
    endtask

    task automatic t_push();
        wait_done();
        chk(16'(cyc), 16'h0008);
        chk(16'(rf[8'h00]), 16'h0004);
        chk(16'(rf[8'h04]), 16'h0005);
        chk(16'(flags_o), 16'h0000);
    endtask

    task automatic t_push_wrap();
        wait_done();
        chk(16'(rf[8'h10]), 16'h0000);
        chk(16'(rf[8'h00]), 16'h00A5);
        chk(16'(flags_o), 16'h0000);
    endtask

    task automatic t_clrc();
        wait_done();
        chk(16'(cyc), 16'h0004);
        chk(16'(flags_o), 16'h0000);
    endtask

    task automatic t_ret(input logic [15:0] pc, input logic [15:0] sp, input logic [15:0] n);
        wait_done();
        chk(16'(cyc), n);
        chk(program_counter_o, pc);
        chk(system_stack_pointer_o, sp);
        chk(prog_addr_o, pc);
    endtask

    initial
    begin
        foreach (prog[i]) prog[i] = 8'h55;
        foreach (rf[i]) rf[i] = 8'h00;
        {prog[0], prog[1], prog[2], prog[3]} = {8'hCF, 8'h83, 8'h00, 8'h01};
        {prog[4], prog[5], prog[6], prog[7], prog[8]} = {8'h83, 8'h10, 8'h11, 8'hCF, 8'hAF};
        prog[16'h101A] = 8'hAF;
        {stk[0], stk[1], stk[2], stk[3]} = {8'h10, 8'h1A, 8'h20, 8'h00};
        {rf[8'h00], rf[8'h01], rf[8'h04]} = {8'h03, 8'h05, 8'h2A};
        {rf[8'h10], rf[8'h11]} = {8'hFF, 8'hA5};
        repeat (16) @(negedge clk_i);
        arst_n_i = 1'b1;
        wait_done();
        t_push();
        t_push_wrap();
        t_clrc();
        t_ret(16'h101A, 16'h0002, 16'h0008);
        @(negedge clk_i);
        ext_stack_i = 1'b1;
        t_ret(16'h2000, 16'h0004, 16'h000A);
        wait_done();
        chk(16'(cyc), 16'h0004);
        end_sim();
    end
endmodule

// ===== verif/uspr_exec_props.sv
// Purpose: Timing and side-effect checks on the execution block's ports
// Assumes: One core clock, asynchronous active-low reset
// Notes:   Instruction lengths are checked as gaps between done pulses
module uspr_exec_props (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        arst_n_i,
    // Observed outputs
    input wire logic [15:0] prog_addr_o,
    input wire logic        rf_wr_en_o,
    input wire logic [15:0] program_counter_o,
    input wire logic [15:0] system_stack_pointer_o,
    input wire logic [7:0]  flags_o,
    input wire logic        instr_done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    a_flags_low_kept: assert property (
        flags_o[6:0] == $past(flags_o[6:0]))
        else $error("non-carry flag changed");
    a_carry_never_set: assert property (!$rose(flags_o[7]))
        else $error("carry rose");
    a_sp_plus_two: assert property ($changed(system_stack_pointer_o) |->
        system_stack_pointer_o == $past(system_stack_pointer_o) + 16'h0002)
        else $error("stack pointer step wrong");
    a_done_one_cycle: assert property (instr_done_o |=> !instr_done_o)
        else $error("done longer than one cycle");
    a_done_min_gap: assert property (instr_done_o |=> !instr_done_o [*3])
        else $error("instruction shorter than four cycles");
    a_done_max_gap: assert property (instr_done_o |-> ##[4:10] instr_done_o)
        else $error("instruction longer than ten cycles");
    a_write_then_done: assert property (rf_wr_en_o |-> ##[1:8] instr_done_o)
        else $error("push write not followed by done");
    a_fetch_new_pc: assert property (
        $changed(system_stack_pointer_o) |-> (prog_addr_o == program_counter_o)
        ##1 $stable(prog_addr_o) [*4])
        else $error("fetch address moved off the loaded counter");

    c_push_write: cover property (rf_wr_en_o);
    c_return: cover property ($changed(system_stack_pointer_o));
    c_done: cover property (instr_done_o);
endmodule
bind uspr_exec uspr_exec_props u_props (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .prog_addr_o(prog_addr_o),
    .rf_wr_en_o(rf_wr_en_o), .program_counter_o(program_counter_o),
    .system_stack_pointer_o(system_stack_pointer_o), .flags_o(flags_o),
    .instr_done_o(instr_done_o)
);
